/* rtl/line_ctrl_pkg.sv */
// Register map, reset values and widths of the I/O line controller
package line_ctrl_pkg;

    // ==========================================================
    // Geometry
    localparam int unsigned LINES    = 32;
    localparam int unsigned ADR_W    = 8;
    localparam int unsigned FUNCS    = 4;

    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] OFS_IRQ_ENABLE   = 8'h00;
    localparam logic [7:0] OFS_IRQ_DISABLE  = 8'h04;
    localparam logic [7:0] OFS_IRQ_MASK     = 8'h08;
    localparam logic [7:0] OFS_IRQ_STATUS   = 8'h0c;
    localparam logic [7:0] OFS_OD_ENABLE    = 8'h10;
    localparam logic [7:0] OFS_OD_DISABLE   = 8'h14;
    localparam logic [7:0] OFS_OD_STATUS    = 8'h18;
    localparam logic [7:0] OFS_PU_DISABLE   = 8'h1c;
    localparam logic [7:0] OFS_PU_ENABLE    = 8'h20;
    localparam logic [7:0] OFS_PU_STATUS    = 8'h24;
    localparam logic [7:0] OFS_SEL_LOW      = 8'h28;
    localparam logic [7:0] OFS_SEL_HIGH     = 8'h2c;
    localparam logic [7:0] OFS_IRQ_CLEAR    = 8'h30;
    localparam logic [7:0] OFS_LOCK         = 8'h34;
    localparam logic [7:0] OFS_CTRL_ACTIVE  = 8'h38;
    localparam logic [7:0] OFS_OUT_DATA     = 8'h3c;
    localparam logic [7:0] OFS_OUT_ENABLE   = 8'h40;

    // ==========================================================
    // Field positions and reset values
    localparam int unsigned LOCK_BIT        = 0;
    localparam logic [31:0] RST_ZERO        = 32'h0000_0000;
    localparam logic [31:0] RST_CTRL_ACTIVE = 32'hffff_ffff;

    // Function codes: upper bit from the high select register
    localparam logic [1:0] FUNC_A = 2'h0;
    localparam logic [1:0] FUNC_B = 2'h1;
    localparam logic [1:0] FUNC_C = 2'h2;
    localparam logic [1:0] FUNC_D = 2'h3;

endpackage

/* rtl/pin_cfg_if.sv */
// Configuration and change flags passed between register file and pin stage
`timescale 1ns/1ps
`default_nettype none
interface pin_cfg_if;
    import line_ctrl_pkg::*;
    logic [LINES-1:0] open_drain;
    logic [LINES-1:0] ctrl_active;
    logic [LINES-1:0] sel_low;
    logic [LINES-1:0] sel_high;
    logic [LINES-1:0] out_data;
    logic [LINES-1:0] out_enable;
    logic [LINES-1:0] change;

    modport regs (output open_drain, ctrl_active, sel_low, sel_high, out_data, out_enable,
                  input change);
    modport pins (input open_drain, ctrl_active, sel_low, sel_high, out_data, out_enable,
                  output change);
endinterface
`default_nettype wire

/* rtl/wb_slave_port.sv */
// Classic Wishbone slave front end: one request at a time, registered answer
`timescale 1ns/1ps
`default_nettype none
module wb_slave_port
    import line_ctrl_pkg::*;
(
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             cyc_i,
    input  wire logic             stb_i,
    input  wire logic             we_i,
    input  wire logic [3:0]       sel_i,
    input  wire logic [31:0]      dat_i,
    input  wire logic [31:0]      rdata_i,
    output logic                  ack_o,
    output logic [31:0]           dat_o,
    output logic                  take_o,
    output logic                  wr_o,
    output logic                  rd_o,
    output logic [31:0]           wmask_o
);
    logic        ack_q;
    logic [31:0] dat_q;

    // A request is taken once; the held request is not retaken while ack stands
    assign take_o  = cyc_i & stb_i & ~ack_q;
    assign wr_o    = take_o & we_i;
    assign rd_o    = take_o & ~we_i;
    assign wmask_o = dat_i & {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
    assign ack_o   = ack_q;
    assign dat_o   = dat_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            dat_q <= RST_ZERO;
        end else begin
            ack_q <= take_o;
            if (rd_o) begin
                dat_q <= rdata_i;
            end
        end
    end
endmodule
`default_nettype wire

/* rtl/pin_stage.sv */
// Pin synchroniser, change detector and per-line drive routing
`timescale 1ns/1ps
`default_nettype none
module pin_stage
    import line_ctrl_pkg::*;
(
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    input  wire logic [LINES-1:0]     pin_i,
    input  wire logic [LINES-1:0]     func_out_i [FUNCS],
    input  wire logic [LINES-1:0]     func_oe_i  [FUNCS],
    pin_cfg_if.pins                   cfg,
    output logic [LINES-1:0]          pin_o,
    output logic [LINES-1:0]          pin_oe_o,
    output logic [LINES-1:0]          level_o
);
    logic [LINES-1:0] meta_q;
    logic [LINES-1:0] sync_q;
    logic [LINES-1:0] last_q;
    logic [LINES-1:0] drv_data;
    logic [LINES-1:0] drv_en;
    logic [LINES-1:0] pin_q;
    logic [LINES-1:0] oe_q;

    assign cfg.change = sync_q ^ last_q;
    assign level_o    = sync_q;
    assign pin_o      = pin_q;
    assign pin_oe_o   = oe_q;

    genvar g;
    generate
        for (g = 0; g < LINES; g++) begin : g_line
            logic [1:0] code;
            logic       f_out;
            logic       f_oe;
            assign code  = {cfg.sel_high[g], cfg.sel_low[g]};
            assign f_out = func_out_i[code][g];
            assign f_oe  = func_oe_i[code][g];
            // Controller owns the pin while active, else the chosen function
            assign drv_data[g] = cfg.ctrl_active[g] ? cfg.out_data[g] : f_out;
            assign drv_en[g]   = cfg.ctrl_active[g] ? cfg.out_enable[g] : f_oe;
        end
    endgenerate

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_q <= RST_ZERO;
            sync_q <= RST_ZERO;
            last_q <= RST_ZERO;
            pin_q  <= RST_ZERO;
            oe_q   <= RST_ZERO;
        end else begin
            meta_q <= pin_i;
            sync_q <= meta_q;
            last_q <= sync_q;
            // Open-drain lines only ever pull low; push-pull drives both levels
            pin_q  <= drv_data & ~cfg.open_drain;
            oe_q   <= drv_en & (~cfg.open_drain | ~drv_data);
        end
    end
endmodule
`default_nettype wire

/* rtl/line_ctrl.sv */
// Top of the 32-line I/O controller: register file, interrupt and pull-up control
//
// Design decisions made here: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Enable write ones turn line interrupts on
// - Disable write ones turn line interrupts off
// - Mask register reads enabled interrupt lines
// - Status bit sets on any detected change
// - Reading status clears all its bits
// - Lock bit blocks open-drain, pull-up, select writes
// - Open-drain enable ones select open-drain drive
// - Open-drain disable ones restore push-pull drive
// - Open-drain line drives low only
// - Push-pull line drives both levels
// - Pull-up disable ones switch pull-up off
// - Pull-up enable ones switch pull-up on
// - Pull-up status reads one when off
// - Two select registers read and write
// - Select code picks function A to D
// - Function drives pin only when controller inactive
module line_ctrl
    import line_ctrl_pkg::*;
(
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    input  wire logic                 cyc_i,
    input  wire logic                 stb_i,
    input  wire logic                 we_i,
    input  wire logic [ADR_W-1:0]     adr_i,
    input  wire logic [3:0]           sel_i,
    input  wire logic [31:0]          dat_i,
    output logic                      ack_o,
    output logic [31:0]               dat_o,
    output logic                      irq_o,
    input  wire logic [LINES-1:0]     pin_i,
    output logic [LINES-1:0]          pin_o,
    output logic [LINES-1:0]          pin_oe_o,
    output logic [LINES-1:0]          pullup_en_o,
    output logic [LINES-1:0]          line_in_o,
    input  wire logic [LINES-1:0]     func_a_out_i,
    input  wire logic [LINES-1:0]     func_a_oe_i,
    input  wire logic [LINES-1:0]     func_b_out_i,
    input  wire logic [LINES-1:0]     func_b_oe_i,
    input  wire logic [LINES-1:0]     func_c_out_i,
    input  wire logic [LINES-1:0]     func_c_oe_i,
    input  wire logic [LINES-1:0]     func_d_out_i,
    input  wire logic [LINES-1:0]     func_d_oe_i
);

    // ==========================================================
    // Bus front end
    logic              take;
    logic              wr;
    logic              rd;
    logic [31:0]       wmask;
    logic [31:0]       rdata;

    wb_slave_port u_bus (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .cyc_i   (cyc_i),
        .stb_i   (stb_i),
        .we_i    (we_i),
        .sel_i   (sel_i),
        .dat_i   (dat_i),
        .rdata_i (rdata),
        .ack_o   (ack_o),
        .dat_o   (dat_o),
        .take_o  (take),
        .wr_o    (wr),
        .rd_o    (rd),
        .wmask_o (wmask)
    );

    // ==========================================================
    // Address decode
    function automatic logic hit(input logic [ADR_W-1:0] a, input logic [7:0] ofs);
        hit = (a[7:2] == ofs[7:2]);
    endfunction

    logic              locked_q;
    logic              wr_open;
    logic              wr_irq_en;
    logic              wr_irq_dis;
    logic              wr_irq_clr;
    logic              rd_status;
    logic              wr_od_en;
    logic              wr_od_dis;
    logic              wr_pu_en;
    logic              wr_pu_dis;
    logic              wr_sel_lo;
    logic              wr_sel_hi;
    logic              wr_lock;
    logic              wr_active;
    logic              wr_odata;
    logic              wr_oen;

    // Locked writes still answer with ack; they simply store nothing
    assign wr_open    = wr & ~locked_q;
    assign wr_irq_en  = wr & hit(adr_i, OFS_IRQ_ENABLE);
    assign wr_irq_dis = wr & hit(adr_i, OFS_IRQ_DISABLE);
    assign wr_irq_clr = wr & hit(adr_i, OFS_IRQ_CLEAR);
    assign rd_status  = rd & hit(adr_i, OFS_IRQ_STATUS);
    assign wr_od_en   = wr_open & hit(adr_i, OFS_OD_ENABLE);
    assign wr_od_dis  = wr_open & hit(adr_i, OFS_OD_DISABLE);
    assign wr_pu_en   = wr_open & hit(adr_i, OFS_PU_ENABLE);
    assign wr_pu_dis  = wr_open & hit(adr_i, OFS_PU_DISABLE);
    assign wr_sel_lo  = wr_open & hit(adr_i, OFS_SEL_LOW);
    assign wr_sel_hi  = wr_open & hit(adr_i, OFS_SEL_HIGH);
    assign wr_lock    = wr & hit(adr_i, OFS_LOCK);
    assign wr_active  = wr & hit(adr_i, OFS_CTRL_ACTIVE);
    assign wr_odata   = wr & hit(adr_i, OFS_OUT_DATA);
    assign wr_oen     = wr & hit(adr_i, OFS_OUT_ENABLE);

    // ==========================================================
    // Stored per-line state
    logic [LINES-1:0]  irq_mask_q;
    logic [LINES-1:0]  irq_mask_d;
    logic [LINES-1:0]  irq_stat_q;
    logic [LINES-1:0]  irq_stat_d;
    logic [LINES-1:0]  od_q;
    logic [LINES-1:0]  od_d;
    logic [LINES-1:0]  pu_off_q;
    logic [LINES-1:0]  pu_off_d;
    logic [LINES-1:0]  sel_lo_q;
    logic [LINES-1:0]  sel_hi_q;
    logic [LINES-1:0]  active_q;
    logic [LINES-1:0]  odata_q;
    logic [LINES-1:0]  oen_q;
    logic [LINES-1:0]  pu_en_q;
    logic              irq_q;
    logic [LINES-1:0]  clr_bits;

    pin_cfg_if cfg ();

    // Byte lanes that a plain read-write access may change
    logic [31:0]       sel_mask;
    assign sel_mask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};

    // Enable/disable pairs: ones in the write set or clear the stored bit
    assign irq_mask_d = wr_irq_en  ? (irq_mask_q | wmask)
                      : wr_irq_dis ? (irq_mask_q & ~wmask)
                      : irq_mask_q;
    assign od_d       = wr_od_en   ? (od_q | wmask)
                      : wr_od_dis  ? (od_q & ~wmask)
                      : od_q;
    assign pu_off_d   = wr_pu_dis  ? (pu_off_q | wmask)
                      : wr_pu_en   ? (pu_off_q & ~wmask)
                      : pu_off_q;

    // A read clears every bit, the clear register only its ones; a change
    // in the same cycle still sets, so no event is lost
    assign clr_bits   = rd_status ? {LINES{1'b1}}
                      : wr_irq_clr ? wmask
                      : RST_ZERO;
    assign irq_stat_d = (irq_stat_q & ~clr_bits) | cfg.change;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_mask_q <= RST_ZERO;
            irq_stat_q <= RST_ZERO;
            od_q       <= RST_ZERO;
            pu_off_q   <= RST_ZERO;
            pu_en_q    <= RST_CTRL_ACTIVE;
            irq_q      <= 1'b0;
        end else begin
            irq_mask_q <= irq_mask_d;
            irq_stat_q <= irq_stat_d;
            od_q       <= od_d;
            pu_off_q   <= pu_off_d;
            pu_en_q    <= ~pu_off_d;
            irq_q      <= |(irq_stat_d & irq_mask_d);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sel_lo_q <= RST_ZERO;
            sel_hi_q <= RST_ZERO;
            locked_q <= 1'b0;
            active_q <= RST_CTRL_ACTIVE;
            odata_q  <= RST_ZERO;
            oen_q    <= RST_ZERO;
        end else begin
            if (wr_sel_lo) begin
                sel_lo_q <= (sel_lo_q & ~sel_mask) | wmask;
            end
            if (wr_sel_hi) begin
                sel_hi_q <= (sel_hi_q & ~sel_mask) | wmask;
            end
            if (wr_lock && sel_i[0]) begin
                locked_q <= dat_i[LOCK_BIT];
            end
            if (wr_active) begin
                active_q <= (active_q & ~sel_mask) | wmask;
            end
            if (wr_odata) begin
                odata_q <= (odata_q & ~sel_mask) | wmask;
            end
            if (wr_oen) begin
                oen_q <= (oen_q & ~sel_mask) | wmask;
            end
        end
    end

    // ==========================================================
    // Read mux; write-only and unmapped offsets read as zero
    logic [31:0] lock_word;
    assign lock_word = {31'h0000_0000, locked_q};

    assign rdata = hit(adr_i, OFS_IRQ_MASK)    ? irq_mask_q
                 : hit(adr_i, OFS_IRQ_STATUS)  ? irq_stat_q
                 : hit(adr_i, OFS_OD_STATUS)   ? od_q
                 : hit(adr_i, OFS_PU_STATUS)   ? pu_off_q
                 : hit(adr_i, OFS_SEL_LOW)     ? sel_lo_q
                 : hit(adr_i, OFS_SEL_HIGH)    ? sel_hi_q
                 : hit(adr_i, OFS_LOCK)        ? lock_word
                 : hit(adr_i, OFS_CTRL_ACTIVE) ? active_q
                 : hit(adr_i, OFS_OUT_DATA)    ? odata_q
                 : hit(adr_i, OFS_OUT_ENABLE)  ? oen_q
                 : RST_ZERO;

    // ==========================================================
    // Pin stage
    assign cfg.open_drain  = od_q;
    assign cfg.ctrl_active = active_q;
    assign cfg.sel_low     = sel_lo_q;
    assign cfg.sel_high    = sel_hi_q;
    assign cfg.out_data    = odata_q;
    assign cfg.out_enable  = oen_q;

    logic [LINES-1:0] func_out [FUNCS];
    logic [LINES-1:0] func_oe  [FUNCS];
    assign func_out[FUNC_A] = func_a_out_i;
    assign func_out[FUNC_B] = func_b_out_i;
    assign func_out[FUNC_C] = func_c_out_i;
    assign func_out[FUNC_D] = func_d_out_i;
    assign func_oe[FUNC_A]  = func_a_oe_i;
    assign func_oe[FUNC_B]  = func_b_oe_i;
    assign func_oe[FUNC_C]  = func_c_oe_i;
    assign func_oe[FUNC_D]  = func_d_oe_i;

    pin_stage u_pins (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .pin_i      (pin_i),
        .func_out_i (func_out),
        .func_oe_i  (func_oe),
        .cfg        (cfg),
        .pin_o      (pin_o),
        .pin_oe_o   (pin_oe_o),
        .level_o    (line_in_o)
    );

    assign irq_o       = irq_q;
    assign pullup_en_o = pu_en_q;

endmodule
`default_nettype wire

/* sim/pin_far_side.sv */
// Far side of the pins: outside drivers, pull-ups and four peripheral functions
`timescale 1ns/1ps
`default_nettype none
module pin_far_side
    import line_ctrl_pkg::*;
(
    input  wire logic             clk_i,
    input  wire logic [LINES-1:0] out_i,
    input  wire logic [LINES-1:0] oe_i,
    input  wire logic [LINES-1:0] pu_i,
    input  wire logic [LINES-1:0] ext_en_i,
    input  wire logic [LINES-1:0] ext_val_i,
    output logic      [LINES-1:0] level_o,
    output logic      [LINES-1:0] fout_o [FUNCS],
    output logic      [LINES-1:0] foe_o
);
    // ==========================================================
    // Pin level; a line nobody holds flips away from its last level
    logic [LINES-1:0] held;
    logic [LINES-1:0] flt_q = '0;
    assign held = oe_i | ext_en_i | pu_i;
    assign level_o = (oe_i & out_i) | (~oe_i & ext_en_i & ext_val_i)
                   | (~oe_i & ~ext_en_i & pu_i) | (~held & flt_q);
    always @(posedge clk_i) begin
        flt_q <= (held & ~level_o) | (~held & flt_q);
    end
    // ==========================================================
    // Each function drives its own marker line high, so a wrong route shows
    for (genvar f = 0; f < FUNCS; f++) begin : g_fn
        assign fout_o[f] = 32'h0000_0001 << f;
    end
    assign foe_o = '1;
endmodule
`default_nettype wire

/* sim/line_ctrl_sva.sv */
// Bus, pin and interrupt assertions for the I/O line controller
`timescale 1ns/1ps
`default_nettype none
module line_ctrl_sva
    import line_ctrl_pkg::*;
(
    input wire logic             clk_i,
    input wire logic             rst_i,
    input wire logic             cyc_i,
    input wire logic             stb_i,
    input wire logic             we_i,
    input wire logic [ADR_W-1:0] adr_i,
    input wire logic [3:0]       sel_i,
    input wire logic [31:0]      dat_i,
    input wire logic             ack_o,
    input wire logic [31:0]      dat_o,
    input wire logic             irq_o,
    input wire logic [LINES-1:0] pin_o,
    input wire logic [LINES-1:0] pin_oe_o,
    input wire logic [LINES-1:0] pullup_en_o,
    input wire logic [LINES-1:0] line_in_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ==========================================================
    // Shadow state rebuilt from bus writes, plus a quiet-cycle counter on line_in_o
    logic             tk, wr, rd, lock_q;
    logic [5:0]       wa;
    logic [31:0]      wm;
    logic [1:0]       quiet_q;
    logic [LINES-1:0] mask_q, od_q, pu_off_q;
    assign tk = cyc_i & stb_i & ~ack_o;
    assign wr = tk & we_i;
    assign rd = tk & ~we_i;
    assign wa = adr_i[7:2];
    assign wm = dat_i & {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mask_q <= '0;
            od_q <= '0;
            pu_off_q <= '0;
            lock_q <= 1'b0;
            quiet_q <= 2'h0;
        end else begin
            if (wr && wa == OFS_IRQ_ENABLE[7:2]) mask_q <= mask_q | wm;
            if (wr && wa == OFS_IRQ_DISABLE[7:2]) mask_q <= mask_q & ~wm;
            if (wr && !lock_q && wa == OFS_OD_ENABLE[7:2]) od_q <= od_q | wm;
            if (wr && !lock_q && wa == OFS_OD_DISABLE[7:2]) od_q <= od_q & ~wm;
            if (wr && !lock_q && wa == OFS_PU_DISABLE[7:2]) pu_off_q <= pu_off_q | wm;
            if (wr && !lock_q && wa == OFS_PU_ENABLE[7:2]) pu_off_q <= pu_off_q & ~wm;
            if (wr && wa == OFS_LOCK[7:2] && sel_i[0]) lock_q <= dat_i[LOCK_BIT];
            // Counts quiet cycles so a pending change cannot mask a missed clear
            quiet_q <= !$stable(line_in_o) ? 2'h0 : (quiet_q == 2'h3 ? quiet_q : quiet_q + 2'h1);
        end
    end
    // ==========================================================
    // Assertions
    ack_timing_a: assert property (tk |=> ack_o)
        else $error("no ack one cycle after a taken request");
    ack_pulse_a: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    mask_read_a: assert property (rd && wa == OFS_IRQ_MASK[7:2] |=> dat_o == $past(mask_q))
        else $error("interrupt mask readback wrong");
    od_read_a: assert property (rd && wa == OFS_OD_STATUS[7:2] |=> dat_o == $past(od_q))
        else $error("open-drain status readback wrong");
    pu_read_a: assert property (rd && wa == OFS_PU_STATUS[7:2] |=> dat_o == $past(pu_off_q))
        else $error("pull-up status readback wrong");
    pu_pin_a: assert property (pullup_en_o == ~pu_off_q || pullup_en_o == ~$past(pu_off_q))
        else $error("pull-up output disagrees with stored state");
    od_low_a: assert property ((pin_o & pin_oe_o & od_q & $past(od_q)) == '0)
        else $error("open-drain line driven high");
    irq_level_a: assert property (rd && wa == OFS_IRQ_STATUS[7:2] |=> $past(irq_o) == |(dat_o & $past(mask_q)))
        else $error("interrupt level disagrees with status and mask");
    irq_quiet_a: assert property (rd && wa == OFS_IRQ_STATUS[7:2] && quiet_q == 2'h3 && $stable(line_in_o)
        ##1 $stable(line_in_o) |=> !irq_o)
        else $error("interrupt stays high after status read");
endmodule
bind line_ctrl line_ctrl_sva u_sva (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
    .ack_o, .dat_o, .irq_o, .pin_o, .pin_oe_o, .pullup_en_o, .line_in_o);
`default_nettype wire

/* sim/line_ctrl_tb_top.sv */
// Self-checking bench for the I/O line controller
`timescale 1ns/1ps
`default_nettype none
module line_ctrl_tb_top
    import line_ctrl_pkg::*;
;
    logic             clk, rst, cyc, stb, we, ack, irq;
    logic [ADR_W-1:0] adr;
    logic [3:0]       sel;
    logic [31:0]      wdat, rdat;
    logic [LINES-1:0] pin_in, pin_out, pin_oe, pull_en, line_in, ext_en, ext_val, foe;
    logic [LINES-1:0] fo [FUNCS];
    int               mismatches, total_checks;

    line_ctrl u_dut (
        .clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
        .sel_i(sel), .dat_i(wdat), .ack_o(ack), .dat_o(rdat), .irq_o(irq), .pin_i(pin_in),
        .pin_o(pin_out), .pin_oe_o(pin_oe), .pullup_en_o(pull_en), .line_in_o(line_in),
        .func_a_out_i(fo[0]), .func_a_oe_i(foe), .func_b_out_i(fo[1]), .func_b_oe_i(foe),
        .func_c_out_i(fo[2]), .func_c_oe_i(foe), .func_d_out_i(fo[3]), .func_d_oe_i(foe)
    );
    pin_far_side u_far (.clk_i(clk), .out_i(pin_out), .oe_i(pin_oe), .pu_i(pull_en),
        .ext_en_i(ext_en), .ext_val_i(ext_val), .level_o(pin_in), .fout_o(fo), .foe_o(foe));

    // ==========================================================
    // Shared tasks
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Classic single cycle; holds everything until ack is sampled high
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hf;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        q = rdat;
        if (n >= 50) check(32'h0, 32'h1);
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        check(q, e);
    endtask

    task automatic flip(input logic [31:0] m);
        ext_val <= ext_val ^ m;
        repeat (6) @(posedge clk);
    endtask

    task automatic end_of_test();
        if (mismatches == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    initial begin
        repeat (3000) @(posedge clk);
        mismatches++;
        end_of_test();
    end

    // ==========================================================
    // Test sequence
    initial begin
        rst = 1'b1;
        {cyc, stb, we, adr, sel, wdat} = '0;
        ext_en = '1;
        ext_val = '0;
        mismatches = 0;
        total_checks = 0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(OFS_IRQ_MASK, RST_ZERO);
        rd(OFS_OD_STATUS, RST_ZERO);
        rd(OFS_PU_STATUS, RST_ZERO);
        rd(OFS_IRQ_ENABLE, RST_ZERO);
        rd(8'hfc, RST_ZERO);
        wr(OFS_IRQ_ENABLE, 32'h0000_00ff);
        wr(OFS_IRQ_DISABLE, 32'h0000_000f);
        wr(OFS_IRQ_ENABLE, 32'h0);
        wr(OFS_IRQ_DISABLE, 32'h0);
        rd(OFS_IRQ_MASK, 32'h0000_00f0);
        flip(32'h0000_0011);
        check(line_in, 32'h0000_0011);
        check({31'h0, irq}, 32'h1);
        rd(OFS_IRQ_STATUS, 32'h0000_0011);
        rd(OFS_IRQ_STATUS, 32'h0);
        check({31'h0, irq}, 32'h0);
        flip(32'h0000_0001);
        check({31'h0, irq}, 32'h0);
        rd(OFS_IRQ_STATUS, 32'h0000_0001);
        flip(32'h0000_0010);
        check({31'h0, irq}, 32'h1);
        wr(OFS_IRQ_CLEAR, 32'h0000_0010);
        check({31'h0, irq}, 32'h0);
        rd(OFS_IRQ_STATUS, 32'h0);
        // Lines 4..0 handed to functions; line 4 function drives low
        wr(OFS_SEL_LOW, 32'h0000_000a);
        wr(OFS_SEL_HIGH, 32'h0000_000c);
        rd(OFS_SEL_LOW, 32'h0000_000a);
        rd(OFS_SEL_HIGH, 32'h0000_000c);
        ext_en <= 32'hffff_ffe0;
        wr(OFS_CTRL_ACTIVE, 32'hffff_ffe0);
        check(pin_oe, 32'h0000_001f);
        check(pin_out & pin_oe, 32'h0000_000f);
        wr(OFS_OD_ENABLE, 32'h0000_0011);
        rd(OFS_OD_STATUS, 32'h0000_0011);
        check(pin_oe, 32'h0000_001e);
        check(pin_out & pin_oe, 32'h0000_000e);
        wr(OFS_OD_DISABLE, 32'h0000_0001);
        rd(OFS_OD_STATUS, 32'h0000_0010);
        check(pin_oe, 32'h0000_001f);
        // Locked writes are acked but leave the state alone
        wr(OFS_LOCK, 32'h1);
        wr(OFS_PU_DISABLE, '1);
        wr(OFS_OD_ENABLE, '1);
        wr(OFS_OD_DISABLE, '1);
        wr(OFS_SEL_LOW, '0);
        wr(OFS_SEL_HIGH, '1);
        rd(OFS_PU_STATUS, 32'h0);
        rd(OFS_OD_STATUS, 32'h0000_0010);
        rd(OFS_SEL_LOW, 32'h0000_000a);
        rd(OFS_SEL_HIGH, 32'h0000_000c);
        wr(OFS_LOCK, 32'h0);
        wr(OFS_PU_DISABLE, 32'h0000_00ff);
        rd(OFS_PU_STATUS, 32'h0000_00ff);
        wr(OFS_PU_ENABLE, 32'h0000_000f);
        rd(OFS_PU_STATUS, 32'h0000_00f0);
        check(pull_en, 32'hffff_ff0f);
        end_of_test();
    end
endmodule
`default_nettype wire
